// [common/epwm_pkg.sv]
// Package with register map, field positions, reset values and timing counts.
package epwm_pkg;
	// Register byte offsets on the AXI4-Lite bus.
	localparam logic [7:0] OFS_DUTY_LO = 8'h00;
	localparam logic [7:0] OFS_DUTY_HI = 8'h04;
	localparam logic [7:0] OFS_CTRL = 8'h08;
	localparam logic [7:0] OFS_SDCFG = 8'h0C;
	localparam logic [7:0] OFS_DBAND = 8'h10;
	localparam logic [7:0] OFS_TB2_CNT = 8'h14;
	localparam logic [7:0] OFS_TB2_CTL = 8'h18;
	localparam logic [7:0] OFS_TB2_PER = 8'h1C;
	localparam logic [7:0] OFS_TB4_CNT = 8'h20;
	localparam logic [7:0] OFS_TB4_CTL = 8'h24;
	localparam logic [7:0] OFS_TB4_PER = 8'h28;
	localparam logic [7:0] OFS_FLAGS1 = 8'h2C;
	localparam logic [7:0] OFS_FLAGS2 = 8'h30;
	localparam logic [7:0] OFS_PINDIR = 8'h34;
	localparam logic [7:0] OFS_MISC = 8'h38;
	// Reset values.
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_PERIOD = 8'hFF;
	localparam logic [3:0] RST_PINDIR = 4'hF;
	// Field positions.
	localparam int CTL_CFG_HI = 7;
	localparam int CTL_CFG_LO = 6;
	localparam int CTL_DLSB_HI = 5;
	localparam int CTL_DLSB_LO = 4;
	localparam int SD_FLAG = 7;
	localparam int SD_SRC_HI = 6;
	localparam int SD_SRC_LO = 4;
	localparam int DB_RESTART = 7;
	localparam int TB_RUN = 2;
	localparam int F1_TB2 = 1;
	localparam int F1_TB4 = 3;
	localparam int F2_OSCFAIL = 7;
	localparam int MISC_TBSEL = 0;
	localparam int MISC_FSCM = 1;
	// Output configuration codes.
	localparam logic [1:0] CFG_SINGLE = 2'h0;
	localparam logic [1:0] CFG_FWD = 2'h1;
	localparam logic [1:0] CFG_HALF = 2'h2;
	localparam logic [1:0] CFG_REV = 2'h3;
	// Mode bits 3:2 must be this for PWM operation.
	localparam logic [1:0] MODE_PWM = 2'h3;
	// Instruction cycle is four clocks; this is its last count.
	localparam logic [1:0] TCY_LAST = 2'h3;
	// AXI response codes.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [core/epwm_core.sv]
// Enhanced PWM unit with two timebases, dead band, auto-shutdown and AXI4-Lite registers.
//
// Design decisions made here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
// How it works
// RL1: Pins undriven after any reset.
// RL2: Mode low bits pick pair polarity.
// RL3: Software sets polarity before enabling outputs.
// RL4: Software waits one full cycle first.
// RL5: Match flag set at period start.
// RL6: Software clears shutdown config first.
// RL7: Duty is low byte plus two bits.
// RL8: Half-bridge dead band from seven bits.
// RL9: Shutdown flag holds outputs in shutdown.
// RL10: Dead-band bit seven enables auto-restart.
// RL11: Prescale bits 1:0, run bit 2.
// RL12: Period comes from period register.
// RL13: Match flag is flags-one bit one.
// RL14: Sleep freezes state, pins keep level.
// RL15: Clock source follows power mode.
// RL16: Clock fail sets flag, internal run.
// RL17: Reset restores registers and inputs.
// RL18: Dead band counts instruction cycles.
// RL19: Three-bit shutdown source encoding.
// RL20: Pair shutdown state low/high/tri.
// RL21: Shutdown flag set, auto or soft clear.
// RL22: Second timebase behaves identically.
module epwm_core (
	// Clock, reset and freeze.
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// AXI4-Lite write address and data.
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	// AXI4-Lite write response.
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	// AXI4-Lite read.
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [7:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	// Shutdown sources from pins and comparators.
	input wire logic fault_input,
	input wire logic cmp1_out,
	input wire logic cmp2_out,
	// Clock monitor.
	input wire logic primary_clk_fail,
	output logic internal_osc_run,
	// Bridge outputs, value and enable.
	output logic pwm_out_a,
	output logic pwm_out_b,
	output logic pwm_out_c,
	output logic pwm_out_d,
	output logic pwm_oe_a,
	output logic pwm_oe_b,
	output logic pwm_oe_c,
	output logic pwm_oe_d
);

////////////////////////////////////////////////////////////////////////////////
	// Software-visible registers.
	logic [7:0] duty_lo_r;
	logic [7:0] duty_hi_r;
	logic [7:0] ctrl_r;
	logic [7:0] sdcfg_r;
	logic [7:0] dband_r;
	logic [7:0] tb_cnt_r [2];
	logic [7:0] tb_ctl_r [2];
	logic [7:0] tb_per_r [2];
	logic [1:0] tb_flag_r;
	logic osc_fail_flag_r;
	logic [3:0] pin_dir_r;
	logic [1:0] misc_r;
	// Bus state.
	logic [7:0] awaddr_r;
	logic [31:0] wdata_r;
	logic wstrb0_r;
	logic aw_have_r;
	logic w_have_r;
	logic do_wr;
	logic [7:0] wbyte;
	// Synchronisers: stage one is only read by stage two.
	logic [3:0] sync1_r;
	logic [3:0] sync2_r;
	// Timebase internals.
	logic [1:0] tcy_r;
	logic tcy_tick;
	logic [3:0] pre_r [2];
	logic [1:0] tb_match;
	logic [1:0] tb_step;
	// PWM datapath.
	logic [9:0] duty_lat_r;
	logic sd_hold_r;
	logic sd_cond;
	logic period_start;
	logic [7:0] sel_cnt;
	logic [9:0] fine_cnt;
	logic mod_on;
	logic [3:0] raw_act;
	logic [1:0] db_act;
	logic [6:0] db_cnt_r [2];
	logic [3:0] act;
	logic [3:0] lvl;
	logic [3:0] oe;

////////////////////////////////////////////////////////////////////////////////
	// Returns one when an address maps to a register.
	function automatic logic addr_ok(input logic [7:0] a);
		addr_ok = (a[1:0] == 2'h0) && (a <= epwm_pkg::OFS_MISC);
	endfunction

	// Prescale divide ratio minus one: 1, 4 or 16.
	function automatic logic [3:0] pre_last(input logic [1:0] s);
		case (s)
			2'h0: pre_last = 4'h0;
			2'h1: pre_last = 4'h3;
			default: pre_last = 4'hF;
		endcase
	endfunction

////////////////////////////////////////////////////////////////////////////////
	// Two-stage synchronisers for the asynchronous inputs.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sync1_r <= 4'h0;
			sync2_r <= 4'h0;
		end else if (clk_en) begin
			sync1_r <= {primary_clk_fail, cmp2_out, cmp1_out, fault_input};
			sync2_r <= sync1_r;
		end
	end

	// Write happens once both address and data are held.
	assign do_wr = aw_have_r && w_have_r && !s_axi_bvalid;
	assign wbyte = wdata_r[7:0];

	// Write channel capture, in either order, and response.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			awaddr_r <= 8'h00;
			wdata_r <= 32'h0000_0000;
			wstrb0_r <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= epwm_pkg::RESP_OKAY;
		end else if (clk_en) begin
			if (s_axi_awvalid && s_axi_awready) begin
				awaddr_r <= s_axi_awaddr;
				aw_have_r <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wdata_r <= s_axi_wdata;
				wstrb0_r <= s_axi_wstrb[0];
				w_have_r <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (do_wr) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= addr_ok(awaddr_r) ? epwm_pkg::RESP_OKAY : epwm_pkg::RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				aw_have_r <= 1'b0;
				w_have_r <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// Read channel: answer one cycle after the address is taken.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= epwm_pkg::RESP_OKAY;
		end else if (clk_en) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= addr_ok(s_axi_araddr) ? epwm_pkg::RESP_OKAY : epwm_pkg::RESP_SLVERR;
				case (s_axi_araddr)
					epwm_pkg::OFS_DUTY_LO: s_axi_rdata <= {24'h000000, duty_lo_r};
					epwm_pkg::OFS_DUTY_HI: s_axi_rdata <= {24'h000000, duty_hi_r};
					epwm_pkg::OFS_CTRL: s_axi_rdata <= {24'h000000, ctrl_r};
					epwm_pkg::OFS_SDCFG: s_axi_rdata <= {24'h000000, sdcfg_r};
					epwm_pkg::OFS_DBAND: s_axi_rdata <= {24'h000000, dband_r};
					epwm_pkg::OFS_TB2_CNT: s_axi_rdata <= {24'h000000, tb_cnt_r[0]};
					epwm_pkg::OFS_TB2_CTL: s_axi_rdata <= {24'h000000, tb_ctl_r[0]};
					epwm_pkg::OFS_TB2_PER: s_axi_rdata <= {24'h000000, tb_per_r[0]};
					epwm_pkg::OFS_TB4_CNT: s_axi_rdata <= {24'h000000, tb_cnt_r[1]};
					epwm_pkg::OFS_TB4_CTL: s_axi_rdata <= {24'h000000, tb_ctl_r[1]};
					epwm_pkg::OFS_TB4_PER: s_axi_rdata <= {24'h000000, tb_per_r[1]};
					epwm_pkg::OFS_FLAGS1: s_axi_rdata <= {28'h0000000, tb_flag_r[1], 1'b0,
						tb_flag_r[0], 1'b0};
					epwm_pkg::OFS_FLAGS2: s_axi_rdata <= {24'h000000, osc_fail_flag_r, 7'h00};
					epwm_pkg::OFS_PINDIR: s_axi_rdata <= {28'h0000000, pin_dir_r};
					epwm_pkg::OFS_MISC: s_axi_rdata <= {30'h0, misc_r};
					default: s_axi_rdata <= 32'h0000_0000;
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

////////////////////////////////////////////////////////////////////////////////
	// Plain control registers; every reset restores them.
	always_ff @(posedge clk or posedge sys_rst) begin
		// RL17: reset restores registers
		if (sys_rst) begin
			duty_lo_r <= epwm_pkg::RST_ZERO;
			ctrl_r <= epwm_pkg::RST_ZERO;
			dband_r <= epwm_pkg::RST_ZERO;
			pin_dir_r <= epwm_pkg::RST_PINDIR;
			misc_r <= 2'h0;
		end else if (clk_en && do_wr && wstrb0_r) begin
			case (awaddr_r)
				epwm_pkg::OFS_DUTY_LO: duty_lo_r <= wbyte;
				epwm_pkg::OFS_CTRL: ctrl_r <= wbyte;
				epwm_pkg::OFS_DBAND: dband_r <= wbyte;
				epwm_pkg::OFS_PINDIR: pin_dir_r <= wbyte[3:0];
				epwm_pkg::OFS_MISC: misc_r <= wbyte[1:0];
				default: ;
			endcase
		end
	end

	// Shutdown configuration; hardware owns the status bit.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sdcfg_r <= epwm_pkg::RST_ZERO;
		end else if (clk_en) begin
			if (do_wr && wstrb0_r && awaddr_r == epwm_pkg::OFS_SDCFG) begin
				sdcfg_r[6:0] <= wbyte[6:0];
				// RL21: writes blocked during cause
				if (!sd_cond) begin
					sdcfg_r[epwm_pkg::SD_FLAG] <= wbyte[epwm_pkg::SD_FLAG];
				end
			end
			// RL21: event sets flag, wins
			if (sd_cond) begin
				sdcfg_r[epwm_pkg::SD_FLAG] <= 1'b1;
			// RL10: auto-restart clears flag
			end else if (dband_r[epwm_pkg::DB_RESTART]) begin
				sdcfg_r[epwm_pkg::SD_FLAG] <= 1'b0;
			end
		end
	end

	// Shutdown source selection from the synchronised inputs.
	always_comb begin
		// RL19: source select encoding
		sd_cond = 1'b0;
		if (sdcfg_r[epwm_pkg::SD_SRC_LO]) begin
			sd_cond = sd_cond | sync2_r[1];
		end
		if (sdcfg_r[epwm_pkg::SD_SRC_LO + 1]) begin
			sd_cond = sd_cond | sync2_r[2];
		end
		if (sdcfg_r[epwm_pkg::SD_SRC_HI]) begin
			sd_cond = sd_cond | sync2_r[0];
		end
	end

	// Clock monitor flag and internal-oscillator run indication.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			osc_fail_flag_r <= 1'b0;
			internal_osc_run <= 1'b0;
		end else if (clk_en) begin
			if (do_wr && wstrb0_r && awaddr_r == epwm_pkg::OFS_FLAGS2) begin
				osc_fail_flag_r <= wbyte[epwm_pkg::F2_OSCFAIL];
			end
			// RL16: failure sets flag, internal
			if (misc_r[epwm_pkg::MISC_FSCM] && sync2_r[3]) begin
				osc_fail_flag_r <= 1'b1;
				internal_osc_run <= 1'b1;
			end
		end
	end

////////////////////////////////////////////////////////////////////////////////
	// Instruction-cycle divider: one tick every four clocks.
	// RL15: counts on supplied clock
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			tcy_r <= 2'h0;
		end else if (clk_en) begin
			tcy_r <= (tcy_r == epwm_pkg::TCY_LAST) ? 2'h0 : tcy_r + 2'h1;
		end
	end
	assign tcy_tick = (tcy_r == epwm_pkg::TCY_LAST);

	// Both timebases share one structure.
	// RL22: identical second timebase
	for (genvar i = 0; i < 2; i++) begin : g_tb
		// RL11: run bit and prescale
		assign tb_step[i] = tcy_tick && tb_ctl_r[i][epwm_pkg::TB_RUN]
			&& (pre_r[i] == pre_last(tb_ctl_r[i][1:0]));
		// RL12: period register match
		assign tb_match[i] = tb_step[i] && (tb_cnt_r[i] == tb_per_r[i]);

		// Prescaler, counter and period registers of one timebase.
		always_ff @(posedge clk or posedge sys_rst) begin
			if (sys_rst) begin
				pre_r[i] <= 4'h0;
				tb_cnt_r[i] <= epwm_pkg::RST_ZERO;
				tb_ctl_r[i] <= epwm_pkg::RST_ZERO;
				tb_per_r[i] <= epwm_pkg::RST_PERIOD;
			// RL14: frozen while clock disabled
			end else if (clk_en) begin
				if (tcy_tick && tb_ctl_r[i][epwm_pkg::TB_RUN]) begin
					pre_r[i] <= tb_step[i] ? 4'h0 : pre_r[i] + 4'h1;
				end
				if (tb_match[i]) begin
					tb_cnt_r[i] <= 8'h00;
				end else if (tb_step[i]) begin
					tb_cnt_r[i] <= tb_cnt_r[i] + 8'h01;
				end
				if (do_wr && wstrb0_r) begin
					if (awaddr_r == (i == 0 ? epwm_pkg::OFS_TB2_CNT : epwm_pkg::OFS_TB4_CNT)) begin
						tb_cnt_r[i] <= wbyte;
					end
					if (awaddr_r == (i == 0 ? epwm_pkg::OFS_TB2_CTL : epwm_pkg::OFS_TB4_CTL)) begin
						tb_ctl_r[i] <= {1'b0, wbyte[6:0]};
					end
					if (awaddr_r == (i == 0 ? epwm_pkg::OFS_TB2_PER : epwm_pkg::OFS_TB4_PER)) begin
						tb_per_r[i] <= wbyte;
					end
				end
			end
		end
	end

	// Match flags: set by a period restart, cleared by writing zero.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			tb_flag_r <= 2'h0;
		end else if (clk_en) begin
			// RL13: software clears flag
			if (do_wr && wstrb0_r && awaddr_r == epwm_pkg::OFS_FLAGS1) begin
				tb_flag_r <= {wbyte[epwm_pkg::F1_TB4], wbyte[epwm_pkg::F1_TB2]};
			end
			// RL5: flag at period start
			if (tb_match[0]) begin
				tb_flag_r[0] <= 1'b1;
			end
			if (tb_match[1]) begin
				tb_flag_r[1] <= 1'b1;
			end
		end
	end

////////////////////////////////////////////////////////////////////////////////
	// Selected timebase drives the PWM.
	assign period_start = tb_match[misc_r[epwm_pkg::MISC_TBSEL]];
	assign sel_cnt = tb_cnt_r[misc_r[epwm_pkg::MISC_TBSEL]];
	assign fine_cnt = {sel_cnt, tcy_r};
	assign mod_on = (ctrl_r[3:2] == epwm_pkg::MODE_PWM) && (fine_cnt < duty_lat_r);

	// Duty latch updated at each period start; shutdown hold set whenever the flag is set, released at a period start.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			duty_lat_r <= 10'h000;
			duty_hi_r <= epwm_pkg::RST_ZERO;
			sd_hold_r <= 1'b0;
		end else if (clk_en) begin
			if (do_wr && wstrb0_r && awaddr_r == epwm_pkg::OFS_DUTY_HI) begin
				duty_hi_r <= wbyte;
			end
			// RL7: duty from byte plus bits
			if (period_start) begin
				duty_lat_r <= {duty_lo_r, ctrl_r[epwm_pkg::CTL_DLSB_HI:epwm_pkg::CTL_DLSB_LO]};
				duty_hi_r <= duty_lo_r;
			end
			// RL9: flag holds shutdown state
			if (sdcfg_r[epwm_pkg::SD_FLAG]) begin
				sd_hold_r <= 1'b1;
			end else if (period_start) begin
				sd_hold_r <= 1'b0;
			end
		end
	end

	// Active levels per pin before dead band, by output configuration.
	always_comb begin
		raw_act = 4'h0;
		// RL7: config bits pick outputs
		case (ctrl_r[epwm_pkg::CTL_CFG_HI:epwm_pkg::CTL_CFG_LO])
			epwm_pkg::CFG_SINGLE: raw_act = {3'h0, mod_on};
			epwm_pkg::CFG_FWD: raw_act = {mod_on, 2'h0, 1'b1};
			epwm_pkg::CFG_HALF: raw_act = {2'h0, !mod_on, mod_on};
			epwm_pkg::CFG_REV: raw_act = {1'b0, 1'b1, mod_on, 1'b0};
			default: raw_act = 4'h0;
		endcase
	end

	// Dead-band counters for A and B in half-bridge mode.
	for (genvar k = 0; k < 2; k++) begin : g_db
		// RL8: seven-bit delay count
		assign db_act[k] = raw_act[k] && (db_cnt_r[k] == dband_r[6:0]);

		// Counts instruction cycles while the raw signal is active.
		always_ff @(posedge clk or posedge sys_rst) begin
			if (sys_rst) begin
				db_cnt_r[k] <= 7'h00;
			end else if (clk_en) begin
				if (!raw_act[k]) begin
					db_cnt_r[k] <= 7'h00;
				// RL18: delay in instruction cycles
				end else if (tcy_tick && db_cnt_r[k] != dband_r[6:0]) begin
					db_cnt_r[k] <= db_cnt_r[k] + 7'h01;
				end
			end
		end
	end

	// Final levels with dead band, polarity and shutdown state.
	always_comb begin
		act = raw_act;
		if (ctrl_r[epwm_pkg::CTL_CFG_HI:epwm_pkg::CTL_CFG_LO] == epwm_pkg::CFG_HALF) begin
			act[1:0] = db_act;
		end
		// RL2: per-pair polarity
		lvl[0] = act[0] ^ ctrl_r[0];
		lvl[2] = act[2] ^ ctrl_r[0];
		lvl[1] = act[1] ^ ctrl_r[1];
		lvl[3] = act[3] ^ ctrl_r[1];
		// RL1: direction reset keeps undriven
		oe = ~pin_dir_r;
		// RL20: pair shutdown states
		if (sd_hold_r) begin
			lvl[0] = sdcfg_r[2];
			lvl[2] = sdcfg_r[2];
			lvl[1] = sdcfg_r[0];
			lvl[3] = sdcfg_r[0];
			if (sdcfg_r[3]) begin
				oe[0] = 1'b0;
				oe[2] = 1'b0;
			end
			if (sdcfg_r[1]) begin
				oe[1] = 1'b0;
				oe[3] = 1'b0;
			end
		end
	end

	// Pin registers; frozen levels hold while the clock is disabled.
	always_ff @(posedge clk or posedge sys_rst) begin
		// RL17: pins return to input
		if (sys_rst) begin
			{pwm_out_d, pwm_out_c, pwm_out_b, pwm_out_a} <= 4'h0;
			{pwm_oe_d, pwm_oe_c, pwm_oe_b, pwm_oe_a} <= 4'h0;
		// RL14: pins keep level
		end else if (clk_en) begin
			{pwm_out_d, pwm_out_c, pwm_out_b, pwm_out_a} <= lvl;
			{pwm_oe_d, pwm_oe_c, pwm_oe_b, pwm_oe_a} <= oe;
		end
	end

endmodule

// [verif/epwm_bridge_model.sv]
// Bridge switch driver model that resolves the four pins and drives the fault line.
`timescale 1ns/1ps
module epwm_bridge_model (
	// Pin values and enables from the unit.
	input wire logic [3:0] drv_val,
	input wire logic [3:0] drv_oe,
	// Overcurrent request from the bench.
	input wire logic trip,
	// Resolved pin levels and fault line.
	output logic [3:0] pin_lvl,
	output logic fault_input
);
	////////////////////////////////////////////////////////////////////////////////
	// floating pins off
	// Pull-downs hold every switch off while its pin is not driven.
	assign pin_lvl = drv_val & drv_oe;
	// fault pin source
	// A commanded trip or a shoot-through on the A/B leg raises the fault line.
	assign fault_input = trip | (pin_lvl[0] & pin_lvl[1]);
endmodule

// [verif/epwm_core_asserts.sv]
// Checker for the pins, bus handshake, freeze and clock monitor of the PWM unit.
`timescale 1ns/1ps
module epwm_core_asserts (
	// Clock, reset and freeze.
	input wire logic clk, sys_rst, clk_en,
	// Register bus.
	input wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
	input wire logic [7:0] s_axi_awaddr, s_axi_araddr,
	input wire logic [31:0] s_axi_wdata, s_axi_rdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
	input wire logic s_axi_rvalid, s_axi_rready,
	input wire logic [1:0] s_axi_bresp, s_axi_rresp,
	// Shutdown sources and clock monitor.
	input wire logic fault_input, cmp1_out, cmp2_out, primary_clk_fail, internal_osc_run,
	// Bridge pins.
	input wire logic pwm_out_a, pwm_out_b, pwm_out_c, pwm_out_d,
	input wire logic pwm_oe_a, pwm_oe_b, pwm_oe_c, pwm_oe_d
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// All pin values and enables in one vector.
	logic [7:0] pins;
	// Shadow of the last shutdown configuration written.
	logic [7:0] sd_r;
	assign pins = {pwm_out_a, pwm_out_b, pwm_out_c, pwm_out_d,
		pwm_oe_a, pwm_oe_b, pwm_oe_c, pwm_oe_d};
	////////////////////////////////////////////////////////////////////////////////
	// Track writes to the shutdown configuration.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sd_r <= 8'h00;
		end else if (clk_en && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
			&& s_axi_awaddr == epwm_pkg::OFS_SDCFG) begin
			sd_r <= s_axi_wdata[7:0];
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	a_reset_hiz: assert property ($fell(sys_rst) |-> pins[3:0] == 4'h0)
		else $error("pins driven right after reset");
	a_sleep_freeze: assert property (!clk_en |=> $stable(pins) && $stable(s_axi_rvalid))
		else $error("pins moved while frozen");
	a_osc_sticky: assert property (internal_osc_run |=> internal_osc_run)
		else $error("internal run flag dropped");
	a_osc_cause: assert property ($rose(internal_osc_run) |-> $past(primary_clk_fail))
		else $error("internal run without clock failure");
	a_fault_tri: assert property ((sd_r[6] && sd_r[3] && fault_input) [*6]
		|-> !pwm_oe_a && !pwm_oe_c)
		else $error("pair A/C driven in tri-state shutdown");
	a_fault_high: assert property ((sd_r[6] && sd_r[3:2] == 2'h1 && fault_input) [*6]
		##0 pwm_oe_a |-> pwm_out_a)
		else $error("pair A/C not high in shutdown");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready && clk_en |=> !s_axi_awready ##1 s_axi_bvalid)
		else $error("write response late");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready && clk_en
		|=> s_axi_rvalid && !s_axi_arready)
		else $error("read data late");
	a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
		&& $stable(s_axi_rdata))
		else $error("read data dropped before accepted");
	// Main scenarios.
	c_fault: cover property (sd_r[6] && fault_input);
	c_sleep: cover property (!clk_en);
	c_osc: cover property ($rose(internal_osc_run));
endmodule
bind epwm_core epwm_core_asserts u_chk (.*);

// [verif/epwm_core_tb.sv]
// Self-checking bench for the enhanced PWM unit.
`timescale 1ns/1ps
module epwm_core_tb;
	// Bench-driven inputs.
	logic clk, sys_rst, clk_en, awvalid, wvalid, bready, arvalid, rready;
	logic cmp1, cmp2, clk_fail, trip;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata;
	// Design outputs and resolved pins.
	wire awready, wready, bvalid, arready, rvalid, fault, osc_run;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [3:0] pv, po, pin;
	// Counters, register model and last read.
	int miscompares, checked, cycles, r, c0;
	int mdl [16];
	logic [31:0] rv;
	logic [1:0] rr;
	logic [7:0] rw_ofs [5] = '{8'h00, 8'h04, 8'h10, 8'h1C, 8'h28};

	epwm_core dut (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .fault_input(fault),
		.cmp1_out(cmp1), .cmp2_out(cmp2), .primary_clk_fail(clk_fail),
		.internal_osc_run(osc_run), .pwm_out_a(pv[0]), .pwm_out_b(pv[1]), .pwm_out_c(pv[2]),
		.pwm_out_d(pv[3]), .pwm_oe_a(po[0]), .pwm_oe_b(po[1]), .pwm_oe_c(po[2]),
		.pwm_oe_d(po[3]));
	epwm_bridge_model u_brg (.drv_val(pv), .drv_oe(po), .trip(trip), .pin_lvl(pin),
		.fault_input(fault));

	// Free-running 200 MHz clock.
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Compares one value and reports a mismatch.
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic give_verdict();
		$display("checked=%0d miscompares=%0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Bus write: address and data offered together, held until taken.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic ad = 1'b0;
		logic dd = 1'b0;
		@(posedge clk);
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		awaddr <= a;
		wdata <= {24'h000000, d};
		bready <= 1'b1;
		do begin
			@(posedge clk);
			ad = ad | (awready === 1'b1);
			dd = dd | (wready === 1'b1);
			if (ad) awvalid <= 1'b0;
			if (dd) wvalid <= 1'b0;
		end while (!(ad && dd));
		do @(posedge clk); while (bvalid !== 1'b1);
		chk(32'(bresp), 32'h0);
		bready <= 1'b0;
	endtask

	// Bus read into rv and rr.
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clk); while (rvalid !== 1'b1);
		rv = rdata;
		rr = rresp;
		rready <= 1'b0;
	endtask

	// Reset for 20 cycles and reload the register model.
	task automatic do_reset();
		sys_rst <= 1'b1;
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		foreach (mdl[i]) mdl[i] = 0;
		mdl[7] = 'hFF;
		mdl[10] = 'hFF;
		mdl[13] = 'hF;
	endtask

	// Reads every word of the map; the last one is a hole.
	task automatic sweep();
		chk(32'(po), 32'h0);
		chk(32'(osc_run), 32'h0);
		for (int i = 0; i < 16; i++) begin
			rd(8'(i * 4));
			chk(rv, (i == 15) ? 32'h0 : 32'(mdl[i]));
			chk(32'(rr), (i == 15) ? 32'(epwm_pkg::RESP_SLVERR) : 32'h0);
		end
	endtask

	// Sets up one output case by the start-up order and counts high pin cycles.
	task automatic pwm_case(input logic t4, input logic [7:0] ctl, duty, db, input int ea, eb);
		logic [7:0] base;
		int ha;
		int hb;
		base = t4 ? epwm_pkg::OFS_TB4_CNT : epwm_pkg::OFS_TB2_CNT;
		wr(epwm_pkg::OFS_PINDIR, 8'h0F);
		wr(epwm_pkg::OFS_SDCFG, 8'h00);
		wr(epwm_pkg::OFS_MISC, {7'h00, t4});
		wr(base + 8'h08, 8'h07);
		wr(epwm_pkg::OFS_CTRL, ctl);
		wr(epwm_pkg::OFS_DUTY_LO, duty);
		wr(epwm_pkg::OFS_DBAND, db);
		wr(epwm_pkg::OFS_SDCFG, 8'h80);
		wr(epwm_pkg::OFS_FLAGS1, 8'h00);
		wr(base + 8'h04, 8'h04);
		repeat (72) @(posedge clk);
		rd(epwm_pkg::OFS_FLAGS1);
		chk(rv & 32'hA, t4 ? 32'h8 : 32'h2);
		wr(epwm_pkg::OFS_PINDIR, 8'h0C);
		repeat (2) @(posedge clk);
		chk(32'({po[0], pv[0]}), 32'h2);
		wr(epwm_pkg::OFS_SDCFG, 8'h00);
		repeat (40) @(posedge clk);
		ha = 0;
		hb = 0;
		repeat (64) begin
			@(posedge clk);
			ha += int'(pin[0]);
			hb += int'(pin[1]);
		end
		chk(32'(ha), 32'(ea));
		if (eb >= 0) chk(32'(hb), 32'(eb));
		wr(base + 8'h04, 8'h00);
	endtask

	// Hang guard.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 30000) begin
			miscompares++;
			give_verdict();
		end
	end

	initial begin
		{awvalid, wvalid, bready, arvalid, rready, cmp1, cmp2, clk_fail, trip} = '0;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		clk_en = 1'b1;
		sys_rst = 1'b1;
		r = $urandom(32'hE33986AE);
		do_reset();
		sweep();
		// Random contents through the plain storage registers.
		foreach (rw_ofs[j]) begin
			r = $urandom_range(255);
			wr(rw_ofs[j], 8'(r));
			rd(rw_ofs[j]);
			chk(rv, 32'(r));
		end
		// Period 32 clocks; duty 9 clocks, inverted, then half bridge with 8-clock dead band.
		pwm_case(1'b0, 8'h1C, 8'h02, 8'h00, 18, -1);
		pwm_case(1'b0, 8'h1D, 8'h02, 8'h00, 46, -1);
		pwm_case(1'b0, 8'h8C, 8'h04, 8'h02, 16, 16);
		pwm_case(1'b1, 8'h1C, 8'h02, 8'h00, 18, -1);
		pwm_case(1'b0, 8'h4C, 8'h02, 8'h00, 64, 0);
		pwm_case(1'b0, 8'hCC, 8'h02, 8'h00, 0, 16);
		// Shutdown states with manual clear.
		wr(epwm_pkg::OFS_PINDIR, 8'h0E);
		wr(epwm_pkg::OFS_DBAND, 8'h00);
		for (int st = 0; st < 3; st++) begin
			wr(epwm_pkg::OFS_SDCFG, 8'h40 | 8'(st << 2));
			trip <= 1'b1;
			repeat (6) @(posedge clk);
			chk(32'(po[0]), 32'(st < 2));
			if (st < 2) chk(32'(pv[0]), 32'(st));
			trip <= 1'b0;
			repeat (6) @(posedge clk);
			rd(epwm_pkg::OFS_SDCFG);
			chk(32'(rv[7]), 32'h1);
			wr(epwm_pkg::OFS_SDCFG, 8'h40 | 8'(st << 2));
			rd(epwm_pkg::OFS_SDCFG);
			chk(32'(rv[7]), 32'h0);
		end
		// Every source code against each cause, with automatic restart.
		wr(epwm_pkg::OFS_DBAND, 8'h80);
		for (int s = 0; s < 8; s++) begin
			for (int k = 0; k < 3; k++) begin
				wr(epwm_pkg::OFS_SDCFG, 8'(s << 4));
				{trip, cmp2, cmp1} <= 3'(1 << k);
				repeat (6) @(posedge clk);
				rd(epwm_pkg::OFS_SDCFG);
				chk(32'(rv[7]), 32'((s >> k) & 1));
				{trip, cmp2, cmp1} <= 3'h0;
				repeat (6) @(posedge clk);
				rd(epwm_pkg::OFS_SDCFG);
				chk(32'(rv[7]), 32'h0);
			end
		end
		// Freeze for 400 cycles while the count steps every 64.
		wr(epwm_pkg::OFS_MISC, 8'h00);
		wr(epwm_pkg::OFS_TB2_PER, 8'hFF);
		wr(epwm_pkg::OFS_TB2_CTL, 8'h06);
		repeat (200) @(posedge clk);
		rd(epwm_pkg::OFS_TB2_CNT);
		c0 = int'(rv);
		clk_en <= 1'b0;
		repeat (400) @(posedge clk);
		clk_en <= 1'b1;
		rd(epwm_pkg::OFS_TB2_CNT);
		chk(32'(rv - 32'(c0) < 32'h2), 32'h1);
		// Clock failure with the monitor on.
		wr(epwm_pkg::OFS_MISC, 8'h02);
		clk_fail <= 1'b1;
		repeat (8) @(posedge clk);
		chk(32'(osc_run), 32'h1);
		rd(epwm_pkg::OFS_FLAGS2);
		chk(32'(rv[7]), 32'h1);
		clk_fail <= 1'b0;
		// Reset in mid-run restores everything.
		do_reset();
		sweep();
		give_verdict();
	end
endmodule
